// >>> design/channel_indicator.sv
// Two-colour status indicator per probe channel
`timescale 1ns/1ns
module channel_indicator #(
  parameter int CH = probe_sel_pkg::CH_TOTAL
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic [CH-1:0] selected,
  input  wire logic [CH-1:0] present,
  input  wire logic          us_on,
  output probe_sel_pkg::led_type led
);
  import probe_sel_pkg::*;

  led_type next_led;

  for (genvar i = 0; i < CH; i++) begin : g_led
    assign next_led.green[i] = selected[i] & present[i] & ~us_on;
    assign next_led.red[i]   = selected[i] & present[i] & us_on;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      led <= '0;
    end else begin
      led <= next_led;
    end
  end

endmodule : channel_indicator

// >>> design/multi_probe_selector.sv
// Probe channel selector with switching interlocks and APB registers
`timescale 1ns/1ns
module multi_probe_selector (
  input  wire logic                                  core_clk,
  input  wire logic                                  rst,
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire probe_sel_pkg::apb_req_type            apb_req,
  output logic [31:0]                                prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  input  wire logic [probe_sel_pkg::CODE_W-1:0]      setup_select_code,
  input  wire logic                                  us_request,
  input  wire logic [probe_sel_pkg::AMP_W-1:0]       amplitude,
  input  wire logic                                  expansion_present,
  input  wire logic [3:0]                            fault_sense,
  output logic [probe_sel_pkg::CH_TOTAL-1:0]         probe_enable,
  output logic [probe_sel_pkg::CODE_W-1:0]           active_setup,
  output probe_sel_pkg::led_type                     led,
  output logic                                       selector_ready_n,
  output logic                                       us_active_n,
  output logic                                       irq
);
  import probe_sel_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  sel_state_type       state;
  sel_state_type       next_state;
  logic [CODE_W-1:0]   current;
  logic [CODE_W-1:0]   next_current;
  logic [CODE_W-1:0]   pending;
  logic [CODE_W-1:0]   next_pending;
  logic                pend_valid;
  logic                next_pend_valid;
  logic                us_on;
  logic                next_us_on;
  logic                next_ready_n;
  logic [CH_TOTAL-1:0] next_probe_enable;
  logic                fault_q;
  logic                quiet;
  logic                fault_any;
  logic                code_ok;
  logic                ev_switch;
  logic                ev_reject;
  logic [CH_TOTAL-1:0] present;

  logic                ctrl_enable;
  logic                next_ctrl_enable;
  logic [IRQ_W-1:0]    irq_status;
  logic [IRQ_W-1:0]    next_irq_status;
  logic [IRQ_W-1:0]    irq_mask;
  logic [IRQ_W-1:0]    next_irq_mask;
  logic [31:0]         next_prdata;
  logic                next_irq;
  logic                wr_en;
  logic                addr_ok;
  logic [IRQ_W-1:0]    events;

  ////////////////////////////////////////////////////////////////////////////
  // Ring-down detector and indicators

  ringdown_detect #(
    .AMP_W  (AMP_W),
    .SETTLE (RINGDOWN_CYCLES)
  ) u_ringdown (
    .core_clk  (core_clk),
    .rst       (rst),
    .amplitude (amplitude),
    .quiet     (quiet)
  );

  always_comb begin
    present = {{(CH_TOTAL-CH_MASTER){expansion_present}}, {CH_MASTER{1'b1}}};
  end

  channel_indicator #(
    .CH (CH_TOTAL)
  ) u_indicator (
    .core_clk (core_clk),
    .rst      (rst),
    .selected (probe_enable),
    .present  (present),
    .us_on    (us_on),
    .led      (led)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Selection and interlocks

  always_comb begin
    fault_any = (|fault_sense) |
                (~expansion_present & (current >= CODE_W'(CH_MASTER)));
    code_ok   = expansion_present | (setup_select_code < CODE_W'(CH_MASTER));
  end

  always_comb begin
    next_state      = state;
    next_current    = current;
    next_pending    = pending;
    next_pend_valid = pend_valid;
    ev_switch       = 1'b0;
    ev_reject       = 1'b0;
    unique case (state)
      SEL_IDLE: begin
        if (fault_any) begin
          next_state = SEL_FAULT;
        end else if (!selector_ready_n && !us_on && setup_select_code != current) begin
          if (code_ok) begin
            next_pending    = setup_select_code;
            next_pend_valid = 1'b1;
            next_state      = SEL_DRAIN;
          end else begin
            ev_reject = 1'b1;
          end
        end
      end
      SEL_DRAIN: begin
        if (fault_any) begin
          next_state      = SEL_FAULT;
          next_pend_valid = 1'b0;
        end else if (quiet) begin
          next_current    = pending;
          next_pend_valid = 1'b0;
          next_state      = SEL_IDLE;
          ev_switch       = 1'b1;
        end
      end
      SEL_FAULT: begin
        next_pend_valid = 1'b0;
        if (!fault_any && quiet) begin
          next_state = SEL_IDLE;
        end
      end
    endcase
    next_us_on        = us_request & (state == SEL_IDLE) & (next_state == SEL_IDLE) &
                        ~fault_any & ctrl_enable;
    next_ready_n      = ~((next_state == SEL_IDLE) & ~next_us_on & ~fault_any &
                          ctrl_enable);
    next_probe_enable = CH_TOTAL'(1) << next_current;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state            <= SEL_IDLE;
      current          <= '0;
      pending          <= '0;
      pend_valid       <= 1'b0;
      us_on            <= 1'b0;
      selector_ready_n <= 1'b1;
      probe_enable     <= CH_TOTAL'(1);
      fault_q          <= 1'b0;
    end else begin
      state            <= next_state;
      current          <= next_current;
      pending          <= next_pending;
      pend_valid       <= next_pend_valid;
      us_on            <= next_us_on;
      selector_ready_n <= next_ready_n;
      probe_enable     <= next_probe_enable;
      fault_q          <= fault_any;
    end
  end

  always_comb begin
    us_active_n  = ~us_on;
    active_setup = current;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB registers and interrupt

  always_comb begin
    pready  = 1'b1;
    addr_ok = (apb_req.paddr == OFS_CTRL) | (apb_req.paddr == OFS_STATUS) |
              (apb_req.paddr == OFS_IRQ_STATUS) | (apb_req.paddr == OFS_IRQ_MASK);
    pslverr = psel & penable & ~addr_ok;
    wr_en   = psel & penable & apb_req.pwrite & addr_ok;
    events  = '0;
    events[IRQ_SWITCH] = ev_switch;
    events[IRQ_FAULT]  = fault_any & ~fault_q;
    events[IRQ_REJECT] = ev_reject;
  end

  always_comb begin
    next_ctrl_enable = ctrl_enable;
    next_irq_mask    = irq_mask;
    next_irq_status  = irq_status;
    next_prdata      = prdata;
    if (wr_en && apb_req.paddr == OFS_CTRL) begin
      next_ctrl_enable = apb_req.pwdata[CTRL_ENABLE_BIT];
    end
    if (wr_en && apb_req.paddr == OFS_IRQ_MASK) begin
      next_irq_mask = apb_req.pwdata[IRQ_W-1:0];
    end
    if (wr_en && apb_req.paddr == OFS_IRQ_STATUS) begin
      next_irq_status = irq_status & ~apb_req.pwdata[IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | events;
    if (psel && !penable && !apb_req.pwrite) begin
      next_prdata = '0;
      unique case (apb_req.paddr)
        OFS_CTRL:       next_prdata[CTRL_ENABLE_BIT] = ctrl_enable;
        OFS_STATUS: begin
          next_prdata[ST_CHAN_LSB +: CODE_W] = current;
          next_prdata[ST_READY]              = ~selector_ready_n;
          next_prdata[ST_US]                 = us_on;
          next_prdata[ST_QUIET]              = quiet;
          next_prdata[ST_PEND]               = pend_valid;
          next_prdata[ST_FAULT]              = fault_any;
        end
        OFS_IRQ_STATUS: next_prdata[IRQ_W-1:0] = irq_status;
        OFS_IRQ_MASK:   next_prdata[IRQ_W-1:0] = irq_mask;
        default:        next_prdata = '0;
      endcase
    end
    next_irq = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_enable <= CTRL_ENABLE_RST;
      irq_mask    <= IRQ_MASK_RST;
      irq_status  <= '0;
      prdata      <= '0;
      irq         <= 1'b0;
    end else begin
      ctrl_enable <= next_ctrl_enable;
      irq_mask    <= next_irq_mask;
      irq_status  <= next_irq_status;
      prdata      <= next_prdata;
      irq         <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  AST_ONE_CHANNEL: assert property (@(posedge core_clk) disable iff (rst)
    $onehot(probe_enable)) else $error("probe enable not one-hot");

  AST_MASTER_ONLY: assert property (@(posedge core_clk) disable iff (rst)
    !expansion_present && !$past(expansion_present) |-> ##1
      probe_enable[CH_TOTAL-1:CH_MASTER] == '0)
    else $error("expansion channel enabled without expansion unit");

  AST_HOLD_US: assert property (@(posedge core_clk) disable iff (rst)
    !us_active_n |=> $stable(probe_enable) && $stable(current))
    else $error("channel changed while ultrasound active");

  AST_RINGDOWN: assert property (@(posedge core_clk) disable iff (rst)
    $changed(current) |-> $past(quiet) && $past(state) == SEL_DRAIN)
    else $error("channel changed before ring-down");

  AST_FAULT_READY: assert property (@(posedge core_clk) disable iff (rst)
    fault_any |=> selector_ready_n) else $error("ready held during fault");

  AST_LED: assert property (@(posedge core_clk) disable iff (rst)
    !us_active_n && !$past(rst) |=> led.red == $past(probe_enable & present))
    else $error("indicator red mismatch");

  AST_SETUP_APPLY: assert property (@(posedge core_clk) disable iff (rst)
    ev_switch |=> active_setup == $past(pending) && probe_enable[active_setup])
    else $error("selected setup not applied");

  AST_READY_IDLE: assert property (@(posedge core_clk) disable iff (rst)
    !selector_ready_n |-> state == SEL_IDLE && us_active_n && !pend_valid)
    else $error("ready while not accepting");

  AST_US_CAUSE: assert property (@(posedge core_clk) disable iff (rst)
    !us_active_n |-> $past(us_request) && $past(state) == SEL_IDLE)
    else $error("ultrasound active without request");

  AST_SAMPLE: assert property (@(posedge core_clk) disable iff (rst)
    $rose(pend_valid) |-> $past(!selector_ready_n) && $past(us_active_n))
    else $error("code sampled while not ready");

  COV_SWITCH: cover property (@(posedge core_clk) disable iff (rst) ev_switch);
  COV_FAULT:  cover property (@(posedge core_clk) disable iff (rst) $rose(fault_any));
  COV_US:     cover property (@(posedge core_clk) disable iff (rst) $fell(us_active_n));
  COV_REJECT: cover property (@(posedge core_clk) disable iff (rst) ev_reject);

endmodule : multi_probe_selector

// >>> design/probe_sel_pkg.sv
// Shared constants and types for the probe channel selector
package probe_sel_pkg;

  localparam int CH_MASTER = 4;
  localparam int CH_TOTAL  = 8;
  localparam int CODE_W    = 3;
  localparam int AMP_W     = 8;

  localparam int CLK_PERIOD_NS   = 50;
  localparam int RINGDOWN_NS     = 1000;
  localparam int RINGDOWN_CYCLES = (RINGDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h0C;

  localparam int         CTRL_ENABLE_BIT = 0;
  localparam logic       CTRL_ENABLE_RST = 1'b1;
  localparam logic [2:0] IRQ_MASK_RST    = 3'h0;

  localparam int IRQ_W      = 3;
  localparam int IRQ_SWITCH = 0;
  localparam int IRQ_FAULT  = 1;
  localparam int IRQ_REJECT = 2;

  localparam int ST_CHAN_LSB = 0;
  localparam int ST_READY    = 4;
  localparam int ST_US       = 5;
  localparam int ST_QUIET    = 6;
  localparam int ST_PEND     = 7;
  localparam int ST_FAULT    = 8;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [CH_TOTAL-1:0] green;
    logic [CH_TOTAL-1:0] red;
  } led_type;

  typedef enum logic [2:0] {
    SEL_IDLE  = 3'b001,
    SEL_DRAIN = 3'b010,
    SEL_FAULT = 3'b100
  } sel_state_type;

endpackage : probe_sel_pkg

// >>> design/ringdown_detect.sv
// Ring-down detector: output amplitude held at zero long enough
`timescale 1ns/1ns
module ringdown_detect #(
  parameter int AMP_W  = probe_sel_pkg::AMP_W,
  parameter int SETTLE = probe_sel_pkg::RINGDOWN_CYCLES
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [AMP_W-1:0] amplitude,
  output logic                  quiet
);
  import probe_sel_pkg::*;

  localparam int CW = $clog2(SETTLE + 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_quiet;

  always_comb begin
    if (amplitude != '0) begin
      next_count = '0;
    end else if (count == CW'(SETTLE)) begin
      next_count = count;
    end else begin
      next_count = count + 1'b1;
    end
    next_quiet = (next_count == CW'(SETTLE));
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      count <= '0;
      quiet <= 1'b0;
    end else begin
      count <= next_count;
      quiet <= next_quiet;
    end
  end

endmodule : ringdown_detect

// >>> tb/automation_model.sv
// Automation controller and generator output model
`timescale 1ns/1ns
module automation_model (
  input  wire logic                             core_clk,
  input  wire logic                             selector_ready_n,
  input  wire logic                             us_active_n,
  output logic [probe_sel_pkg::CODE_W-1:0]      setup_select_code,
  output logic                                  us_request,
  output logic [probe_sel_pkg::AMP_W-1:0]       amplitude
);
  import probe_sel_pkg::*;
  int hum_left = 0;
  initial begin
    setup_select_code = 3'h0;
    us_request        = 1'b0;
    amplitude         = 8'h00;
  end
  // Output decays in steps once drive stops
  always @(posedge core_clk) begin
    if (us_active_n === 1'b0) begin
      amplitude <= 8'hA0;
    end else if (hum_left > 0) begin
      amplitude <= 8'h10;
      hum_left  <= hum_left - 1;
    end else if (amplitude > 8'h20) begin
      amplitude <= amplitude - 8'h20;
    end else begin
      amplitude <= 8'h00;
    end
  end
  // Code change waits for ready unless told to ignore it
  task automatic pick(input logic [CODE_W-1:0] c, input logic ign);
    for (int i = 0; i < 400 && !ign && selector_ready_n !== 1'b0; i++) begin
      @(posedge core_clk);
    end
    @(posedge core_clk);
    setup_select_code <= c;
  endtask : pick
  task automatic hum(input int n);
    @(posedge core_clk);
    hum_left <= n;
  endtask : hum
  task automatic set_us(input logic v);
    @(posedge core_clk);
    us_request <= v;
  endtask : set_us
endmodule : automation_model

// >>> tb/tb_top.sv
// Self-checking bench for the probe channel selector
`timescale 1ns/1ns
module tb_top;
  import probe_sel_pkg::*;
  logic                core_clk = 1'b0;
  logic                rst = 1'b1;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  apb_req_type         apb_req = '0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic [CODE_W-1:0]   code;
  logic                us_req;
  logic [AMP_W-1:0]    amp;
  logic                expansion_present = 1'b0;
  logic [3:0]          fault_sense = 4'h0;
  logic [CH_TOTAL-1:0] probe_enable;
  logic [CODE_W-1:0]   active_setup;
  led_type             led;
  logic                ready_n;
  logic                us_active_n;
  logic                irq;
  int                  err_total = 0;
  int                  checks = 0;
  logic [31:0]         d;
  logic                e;

  multi_probe_selector uut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .setup_select_code(code), .us_request(us_req), .amplitude(amp),
    .expansion_present(expansion_present), .fault_sense(fault_sense),
    .probe_enable(probe_enable), .active_setup(active_setup), .led(led),
    .selector_ready_n(ready_n), .us_active_n(us_active_n), .irq(irq));
  automation_model auto_ctl (.core_clk(core_clk), .selector_ready_n(ready_n),
    .us_active_n(us_active_n), .setup_select_code(code), .us_request(us_req),
    .amplitude(amp));

  initial begin
    forever #25 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    apb_req <= '{a, w, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    chk("pready", 1, pready);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_rdy(input logic v);
    for (int i = 0; i < 400 && ready_n !== v; i++) @(negedge core_clk);
    chk("ready_n", v, ready_n);
  endtask : wait_rdy
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("rst_en", 8'h01, probe_enable);
    chk("rst_rdy", 1, ready_n);
    chk("rst_us", 1, us_active_n);
    chk("rst_irq", 0, irq);
  endtask : t_reset
  task automatic t_regs;
    apb(0, OFS_CTRL, 0);
    chk("ctrl", 1, d);
    apb(0, OFS_IRQ_MASK, 0);
    chk("mask", 0, d);
    apb(0, 8'h10, 0);
    chk("unmap_d", 0, d);
    chk("unmap_err", 1, e);
    apb(1, OFS_CTRL, 0);
    wait_rdy(1);
    apb(1, OFS_CTRL, 1);
  endtask : t_regs
  task automatic t_switch(input logic [CODE_W-1:0] c);
    wait_rdy(0);
    auto_ctl.pick(c, 0);
    wait_rdy(1);
    wait_rdy(0);
    repeat (2) @(negedge core_clk);
    chk("enable", 8'h01 << c, probe_enable);
    chk("setup", c, active_setup);
    chk("green", 8'h01 << c, led.green);
  endtask : t_switch
  task automatic t_ringdown;
    int n;
    wait_rdy(0);
    auto_ctl.hum(12);
    @(posedge core_clk);
    auto_ctl.pick(2, 1);
    for (n = 0; n < 100 && active_setup !== 3'h2; n++) @(negedge core_clk);
    chk("settle", 1, n >= 10 + RINGDOWN_CYCLES && n <= 17 + RINGDOWN_CYCLES);
  endtask : t_ringdown
  task automatic t_reject;
    apb(1, OFS_IRQ_STATUS, 7);
    auto_ctl.pick(5, 0);
    repeat (40) @(negedge core_clk);
    chk("rej_en", 8'h04, probe_enable);
    apb(0, OFS_IRQ_STATUS, 0);
    chk("rej_irq", 1, d[IRQ_REJECT]);
    auto_ctl.pick(2, 1);
    expansion_present <= 1'b1;
    t_switch(5);
  endtask : t_reject
  task automatic t_weld;
    auto_ctl.set_us(1);
    for (int i = 0; i < 20 && us_active_n !== 1'b0; i++) @(negedge core_clk);
    repeat (2) @(negedge core_clk);
    chk("us_n", 0, us_active_n);
    chk("red", 8'h20, led.red);
    auto_ctl.pick(1, 1);
    repeat (30) @(negedge core_clk);
    chk("hold_en", 8'h20, probe_enable);
    chk("hold_setup", 5, active_setup);
    auto_ctl.pick(5, 1);
    auto_ctl.set_us(0);
    repeat (4) @(negedge core_clk);
    chk("red_off", 0, led.red);
  endtask : t_weld
  task automatic t_irq;
    apb(1, OFS_IRQ_STATUS, 7);
    apb(1, OFS_IRQ_MASK, 1);
    t_switch(4);
    chk("irq_on", 1, irq);
    apb(1, OFS_IRQ_STATUS, 1);
    repeat (2) @(negedge core_clk);
    chk("irq_clr", 0, irq);
    apb(1, OFS_IRQ_MASK, 0);
    t_switch(6);
    chk("irq_mask", 0, irq);
    apb(0, OFS_IRQ_STATUS, 0);
    chk("irq_st", 1, d);
    apb(1, OFS_IRQ_STATUS, 1);
  endtask : t_irq
  task automatic t_fault;
    fault_sense <= 4'h4;
    repeat (2) @(negedge core_clk);
    chk("flt_rdy", 1, ready_n);
    auto_ctl.set_us(1);
    repeat (3) @(negedge core_clk);
    chk("flt_us", 1, us_active_n);
    apb(0, OFS_STATUS, 0);
    chk("flt_st", 1, d[ST_FAULT]);
    apb(0, OFS_IRQ_STATUS, 0);
    chk("flt_irq", 1, d[IRQ_FAULT]);
    auto_ctl.set_us(0);
    fault_sense <= 4'h0;
    wait_rdy(0);
  endtask : t_fault
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge core_clk) begin
    if (!rst) chk("onehot", 1, $onehot(probe_enable));
  end
  initial begin
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    t_reset();
    @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    for (int c = 1; c < CH_MASTER; c++) t_switch(c);
    t_ringdown();
    t_switch(0);
    t_switch(2);
    t_reject();
    t_weld();
    t_irq();
    t_fault();
    report_and_stop();
  end
  initial begin
    #(20000 * 50);
    err_total++;
    report_and_stop();
  end
endmodule : tb_top
